// file: verilog/pbc_pkg.sv
/*
  Constants for the basic control/status register pair: management
  frame coding, register indices, bit positions, reset values and timing.
  Assumes a single core clock at 125 MHz.
*/
`default_nettype none
package pbc_pkg;
  // register indices on the management frame address field
  localparam logic [4:0] REG_CTRL_IDX = 5'h00;
  localparam logic [4:0] REG_STAT_IDX = 5'h01;

  // basic_mode_control bit positions
  localparam int CTRL_SPD_LSB = 13;
  localparam int CTRL_AN_EN = 12;
  localparam int CTRL_ISOLATE = 10;
  localparam int CTRL_RESTART = 9;
  localparam int CTRL_DUPLEX = 8;
  localparam int CTRL_COLTEST = 7;
  localparam int CTRL_SPD_MSB = 6;
  localparam logic CTRL_SPD_MSB_RST = 1'b1;
  localparam logic CTRL_SPD_LSB_RST = 1'b0;

  // basic_mode_status bit positions and fixed part
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_REM_FAULT = 4;
  localparam int STAT_LINK = 2;
  localparam logic [15:0] STAT_FIXED = 16'h7948;

  // forced speed encodings {msb, lsb}
  localparam logic [1:0] SPD_10 = 2'h0;
  localparam logic [1:0] SPD_100 = 2'h1;
  localparam logic [1:0] SPD_1000 = 2'h2;

  // management frame coding
  localparam logic [5:0] PREAMBLE_BITS = 6'h20;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [5:0] HDR_LAST = 6'h0b;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [5:0] SKIP_LAST = 6'h11;

  // collision test timing, bit times at the 100 Mb/s rate
  localparam int CORE_CLK_PS = 8000;
  localparam int BIT_PS_100M = 10000;
  localparam int COL_ON_BITS = 512;
  localparam int COL_OFF_BITS = 4;
  localparam int COL_ON_MAX_CYC = (COL_ON_BITS * BIT_PS_100M) / CORE_CLK_PS;
  localparam int COL_OFF_MAX_CYC = (COL_OFF_BITS * BIT_PS_100M) / CORE_CLK_PS;

  typedef enum logic [3:0] {
    S_PRE, S_IDLE, S_ST, S_HDR, S_SKIP, S_WTA, S_WDAT, S_RTA, S_RDAT
  } pbc_mdio_state_t;
endpackage
`default_nettype wire

// file: verilog/pbc_pin_sync.sv
/*
  Three-stage synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to core_clk; output lags by four edges.
*/
`timescale 1ns/1ps
`default_nettype none
module pbc_pin_sync import pbc_pkg::*; #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pin and filtered level
  input wire logic pin,
  output logic level
);
  logic s1_q, s2_q, s3_q, lvl_q, lvl_d;

  always_comb begin
    lvl_d = lvl_q;
    // change accepted only when second and third stages agree
    if (s2_q == s3_q) begin
      lvl_d = s3_q;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level = lvl_q;
endmodule // pbc_pin_sync
`default_nettype wire

// file: verilog/pbc_regs.sv
/*
  Basic mode control and status registers behind a management frame slave,
  with restart handshake, forced mode outputs and collision test.
  Assumes mac_tx_en and the negotiation/link inputs are on core_clk;
  mdc and mdio come from pins; straps are stable around reset release.
*/
// Operation
// - isolate bit cuts the port off the MAC side; management still works.
// - writing restart with negotiation enabled restarts it; otherwise ignored.
// - restart reads 1 until the restart has begun, then self-clears.
// - writing 0 to restart never cancels a pending restart.
// - duplex bit forces full or half duplex; reset value from a strap.
// - collision test raises collision within 512 bit times of transmit enable.
// - collision test drops collision within 4 bit times of enable falling.
// - speed msb bit pairs with bit 13, resets to 1.
// - speed field 00=10M, 01=100M, 10=1000M, 11 reserved.
// - forced speed and duplex apply only while negotiation is disabled.
// - control bits 5..0 ignore writes and read 0.
// - status bits 15..8 are fixed ability constants.
// - status bit 7 reads 0.
// - status bit 6 reads 1; frames accepted without preamble after first.
// - status bit 5 shows negotiation complete, resets 0.
// - remote fault latches high until status is read or reset.
// - status bit 3 always reads 1.
// - link status latches low; returns high only on a read with good link.
`timescale 1ns/1ps
`default_nettype none
module pbc_regs import pbc_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // configuration straps
  input wire logic strap_an_enable,
  input wire logic strap_full_duplex,
  input wire logic [4:0] strap_phy_addr,
  // serial management pins
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  // MAC side
  input wire logic mac_tx_en,
  output logic mac_col,
  output logic mii_isolate,
  // negotiation engine
  output logic an_restart_req,
  input wire logic an_restart_ack,
  input wire logic an_done,
  output logic an_enable,
  // forced mode
  output logic force_active,
  output logic [1:0] force_speed,
  output logic force_duplex,
  // link events
  input wire logic far_fault_evt,
  input wire logic link_ok
);
  logic mdc_s, mdio_s;
  pbc_pin_sync #(.RST_VAL(1'b0)) u_mdc_sync (
    .core_clk(core_clk), .rst(rst), .pin(mdc), .level(mdc_s)
  );
  // idle data line floats high, so its stages reset high
  pbc_pin_sync #(.RST_VAL(1'b1)) u_mdio_sync (
    .core_clk(core_clk), .rst(rst), .pin(mdio_i), .level(mdio_s)
  );
  // frame engine state
  pbc_mdio_state_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [4:0] reg_q, reg_d;
  logic mdc_prev_q;
  logic mdo_q, mdo_d, oe_q, oe_d;
  logic rd_req_q, rd_req_d, rd_done_q, rd_done_d, wr_q, wr_d;
  logic mdc_rise;
  logic [11:0] hdr;
  // register state
  logic strap_done_q;
  logic [4:0] phy_addr_q, phy_addr_d;
  logic an_en_q, an_en_d, spd_lsb_q, spd_lsb_d, spd_msb_q, spd_msb_d;
  logic isolate_q, isolate_d, duplex_q, duplex_d, coltest_q, coltest_d;
  logic pending_q, pending_d;
  logic rf_q, rf_d, link_q, link_d;
  logic col_q, col_d;
  logic [15:0] rdata_q, rdata_d;
  logic [15:0] ctrl_w, stat_w;
  assign mdc_rise = mdc_s & ~mdc_prev_q;
  assign hdr = {sh_q[10:0], mdio_s};
  // frame engine: samples on MDC rise, drives read data after it
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    reg_d = reg_q;
    mdo_d = mdo_q;
    oe_d = oe_q;
    rd_req_d = 1'b0;
    rd_done_d = 1'b0;
    wr_d = 1'b0;
    if (mdc_rise) begin
      case (st_q)
        S_PRE: begin
          // full preamble only needed here; afterwards S_IDLE skips it
          if (mdio_s) begin
            if (cnt_q != PREAMBLE_BITS) begin
              cnt_d = cnt_q + 6'h01;
            end
          end else if (cnt_q == PREAMBLE_BITS) begin
            st_d = S_ST;
          end else begin
            cnt_d = 6'h00;
          end
        end
        S_IDLE: begin
          if (!mdio_s) begin
            st_d = S_ST;
          end
        end
        S_ST: begin
          cnt_d = 6'h00;
          st_d = mdio_s ? S_HDR : S_PRE;
        end
        S_HDR: begin
          sh_d = {sh_q[14:0], mdio_s};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == HDR_LAST) begin
            cnt_d = 6'h00;
            reg_d = hdr[4:0];
            if (hdr[11:10] == OP_READ) begin
              st_d = (hdr[9:5] == phy_addr_q) ? S_RTA : S_SKIP;
              rd_req_d = (hdr[9:5] == phy_addr_q);
            end else if (hdr[11:10] == OP_WRITE) begin
              st_d = (hdr[9:5] == phy_addr_q) ? S_WTA : S_SKIP;
            end else begin
              st_d = S_PRE; // bad opcode: preamble needed again
            end
          end
        end
        S_SKIP: begin
          // frame for another address: let turnaround and data pass
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == SKIP_LAST) begin
            st_d = S_IDLE;
          end
        end
        S_WTA: begin
          cnt_d = cnt_q + 6'h01;
          if ((cnt_q == 6'h00) != mdio_s) begin
            st_d = S_PRE; // bad turnaround: preamble needed again
            cnt_d = 6'h00;
          end else if (cnt_q != 6'h00) begin
            st_d = S_WDAT;
            cnt_d = 6'h00;
          end
        end
        S_WDAT: begin
          sh_d = {sh_q[14:0], mdio_s};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == DATA_LAST) begin
            wr_d = 1'b1;
            st_d = S_IDLE;
          end
        end
        S_RTA: begin
          // first turnaround bit left floating, second driven low
          if (cnt_q == 6'h00) begin
            cnt_d = 6'h01;
            oe_d = 1'b1;
            mdo_d = 1'b0;
          end else begin
            cnt_d = 6'h00;
            mdo_d = rdata_q[15];
            sh_d = {rdata_q[14:0], 1'b0};
            st_d = S_RDAT;
          end
        end
        S_RDAT: begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == DATA_LAST) begin
            oe_d = 1'b0;
            mdo_d = 1'b1;
            rd_done_d = 1'b1;
            st_d = S_IDLE;
          end else begin
            mdo_d = sh_q[15];
            sh_d = {sh_q[14:0], 1'b0};
          end
        end
        default: begin
          st_d = S_PRE;
          cnt_d = 6'h00;
          oe_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_q <= S_PRE;
      cnt_q <= 6'h00;
      sh_q <= 16'h0000;
      reg_q <= 5'h00;
      mdc_prev_q <= 1'b0;
      mdo_q <= 1'b1;
      oe_q <= 1'b0;
      rd_req_q <= 1'b0;
      rd_done_q <= 1'b0;
      wr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      reg_q <= reg_d;
      mdc_prev_q <= mdc_s;
      mdo_q <= mdo_d;
      oe_q <= oe_d;
      rd_req_q <= rd_req_d;
      rd_done_q <= rd_done_d;
      wr_q <= wr_d;
    end
  end

  // read words
  always_comb begin
    ctrl_w = 16'h0000; // unheld and reserved bits read 0
    ctrl_w[CTRL_SPD_LSB] = spd_lsb_q;
    ctrl_w[CTRL_AN_EN] = an_en_q;
    ctrl_w[CTRL_ISOLATE] = isolate_q;
    ctrl_w[CTRL_RESTART] = pending_q;
    ctrl_w[CTRL_DUPLEX] = duplex_q;
    ctrl_w[CTRL_COLTEST] = coltest_q;
    ctrl_w[CTRL_SPD_MSB] = spd_msb_q;
    stat_w = STAT_FIXED;
    stat_w[STAT_AN_DONE] = an_done;
    stat_w[STAT_REM_FAULT] = rf_q;
    stat_w[STAT_LINK] = link_q;
  end

  // control and status registers
  always_comb begin
    phy_addr_d = phy_addr_q;
    an_en_d = an_en_q;
    spd_lsb_d = spd_lsb_q;
    spd_msb_d = spd_msb_q;
    isolate_d = isolate_q;
    duplex_d = duplex_q;
    coltest_d = coltest_q;
    pending_d = pending_q;
    rf_d = rf_q;
    link_d = link_q;
    rdata_d = rdata_q;
    if (!strap_done_q) begin
      phy_addr_d = strap_phy_addr;
      an_en_d = strap_an_enable;
      duplex_d = strap_full_duplex;
    end
    if (an_restart_ack) begin
      pending_d = 1'b0;
    end
    if (wr_q && reg_q == REG_CTRL_IDX) begin
      spd_lsb_d = sh_q[CTRL_SPD_LSB];
      an_en_d = sh_q[CTRL_AN_EN];
      isolate_d = sh_q[CTRL_ISOLATE];
      duplex_d = sh_q[CTRL_DUPLEX];
      coltest_d = sh_q[CTRL_COLTEST];
      spd_msb_d = sh_q[CTRL_SPD_MSB];
      // a written 0 leaves a pending restart alone; set beats ack
      if (sh_q[CTRL_RESTART] && sh_q[CTRL_AN_EN]) begin
        pending_d = 1'b1;
      end
    end
    // snapshot taken when the header ends so clears cannot change the answer
    if (rd_req_q) begin
      rdata_d = (reg_q == REG_CTRL_IDX) ? ctrl_w :
                (reg_q == REG_STAT_IDX) ? stat_w : 16'h0000;
    end
    if (rd_done_q && reg_q == REG_STAT_IDX) begin
      rf_d = 1'b0;
      link_d = link_ok;
    end
    if (far_fault_evt) begin
      rf_d = 1'b1;
    end
    if (!link_ok) begin
      link_d = 1'b0;
    end
  end

  // collision test; the registered path gives one cycle, well inside both limits
  always_comb begin
    col_d = coltest_q & mac_tx_en & ~isolate_q;
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strap_done_q <= 1'b0;
      phy_addr_q <= 5'h00;
      an_en_q <= 1'b0;
      spd_lsb_q <= CTRL_SPD_LSB_RST;
      spd_msb_q <= CTRL_SPD_MSB_RST;
      isolate_q <= 1'b0;
      duplex_q <= 1'b0;
      coltest_q <= 1'b0;
      pending_q <= 1'b0;
      rf_q <= 1'b0;
      link_q <= 1'b0;
      rdata_q <= 16'h0000;
      col_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      phy_addr_q <= phy_addr_d;
      an_en_q <= an_en_d;
      spd_lsb_q <= spd_lsb_d;
      spd_msb_q <= spd_msb_d;
      isolate_q <= isolate_d;
      duplex_q <= duplex_d;
      coltest_q <= coltest_d;
      pending_q <= pending_d;
      rf_q <= rf_d;
      link_q <= link_d;
      rdata_q <= rdata_d;
      col_q <= col_d;
    end
  end

  assign mdio_o = mdo_q;
  assign mdio_oe = oe_q;
  assign mac_col = col_q;
  assign mii_isolate = isolate_q;
  assign an_restart_req = pending_q;
  assign an_enable = an_en_q;
  // forced values steer the port only while negotiation is off
  assign force_active = ~an_en_q;
  assign force_speed = {spd_msb_q, spd_lsb_q};
  assign force_duplex = duplex_q;
endmodule // pbc_regs
`default_nettype wire

// file: tb/pbc_regs_monitor.sv
/*
  Port checker for the basic control/status register block.
  Assumes one core clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module pbc_regs_monitor (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // watched ports
  input wire logic mdio_o,
  input wire logic mdio_oe,
  input wire logic mac_tx_en,
  input wire logic mac_col,
  input wire logic mii_isolate,
  input wire logic an_restart_req,
  input wire logic an_restart_ack,
  input wire logic an_enable,
  input wire logic force_active,
  input wire logic [1:0] force_speed
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  col_drop_a: assert property (!mac_tx_en |=> !mac_col)
    else $error("collision held after transmit enable fell");
  col_cause_a: assert property (mac_col |-> $past(mac_tx_en))
    else $error("collision without transmit enable");
  col_isolate_a: assert property (mii_isolate |=> !mac_col)
    else $error("collision shown while isolated");
  restart_gate_a: assert property ($rose(an_restart_req) |-> an_enable)
    else $error("restart pending with negotiation disabled");
  restart_hold_a: assert property (an_restart_req && !an_restart_ack |=> an_restart_req)
    else $error("pending restart lost");
  restart_clear_a: assert property ($fell(an_restart_req) |-> $past(an_restart_ack))
    else $error("restart cleared without acknowledge");
  force_mode_a: assert property (force_active == !an_enable)
    else $error("forced mode disagrees with negotiation enable");
  speed_reset_a: assert property ($fell(rst) |-> force_speed == 2'h2 && !mac_col)
    else $error("forced speed reset value wrong");
  turn_zero_a: assert property ($rose(mdio_oe) |-> !mdio_o)
    else $error("turnaround not driven low");

  cover property ($rose(mac_col));
  cover property ($rose(an_restart_req));
  cover property ($rose(mdio_oe));
endmodule // pbc_regs_monitor

bind pbc_regs pbc_regs_monitor i_pbc_regs_monitor (
  .core_clk(core_clk), .rst(rst), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
  .mac_tx_en(mac_tx_en), .mac_col(mac_col), .mii_isolate(mii_isolate),
  .an_restart_req(an_restart_req), .an_restart_ack(an_restart_ack),
  .an_enable(an_enable), .force_active(force_active), .force_speed(force_speed)
);
`default_nettype wire

// file: tb/pbc_mgmt_master.sv
/*
  Station management master model: frames on MDC/MDIO, 16 core cycles a bit.
  Assumes the bench resolves the data wire (pull-up) and returns it on mdio_in.
*/
`timescale 1ns/1ps
`default_nettype none
module pbc_mgmt_master (
  // clock
  input wire logic core_clk,
  // management pins
  output logic mdc,
  output logic mdo,
  output logic mdo_en,
  input wire logic mdio_in
);
  logic need_pre = 1'b1;
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
    mdo_en = 1'b1;
  end
  // sample just before the rise: the slave's bit stands until then
  task automatic bclk(input logic b, input logic en, output logic s);
    mdo = b;
    mdo_en = en;
    repeat (8) @(negedge core_clk);
    s = mdio_in;
    mdc = 1'b1;
    repeat (8) @(negedge core_clk);
    mdc = 1'b0;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    f = {32'hffff_ffff, 2'b01, op, pa, ra, (op == 2'h1) ? 2'b10 : 2'b11, wd};
    for (int i = need_pre ? 63 : 31; i >= 0; i--) begin
      bclk(f[i], (op == 2'h1) || (i > 17), s);
      if (i < 16) rd[i] = s;
    end
    need_pre = 1'b0;
    mdo = 1'b1;
    repeat (64) @(negedge core_clk);
    bclk(1'b1, 1'b1, s);
  endtask
endmodule // pbc_mgmt_master
`default_nettype wire

// file: tb/phy_basic_control_status_regs_test.sv
/*
  Self-checking bench for pbc_regs through its management frames.
  Assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module phy_basic_control_status_regs_test import pbc_pkg::*;;
  localparam logic [4:0] PA = 5'h05;
  logic core_clk = 1'b0, rst = 1'b1, mac_tx_en = 1'b0, an_restart_ack = 1'b0;
  logic an_done = 1'b0, far_fault_evt = 1'b0, link_ok = 1'b1;
  logic strap_an = 1'b1, strap_fd = 1'b1;
  logic mdc, mdo, mdo_en, mdio_o, mdio_oe, mdio_w, mac_col, mii_isolate;
  logic an_restart_req, an_enable, force_active, force_duplex;
  logic [1:0] force_speed, sp;
  int error_cnt = 0, n_checks = 0, cyc = 0;

  // design drive wins; a released wire floats up
  assign mdio_w = mdio_oe ? mdio_o : (mdo_en ? mdo : 1'b1);

  pbc_regs i_pbc_regs (.core_clk(core_clk), .rst(rst), .strap_an_enable(strap_an),
    .strap_full_duplex(strap_fd), .strap_phy_addr(PA), .mdc(mdc), .mdio_i(mdio_w),
    .mdio_o(mdio_o), .mdio_oe(mdio_oe), .mac_tx_en(mac_tx_en), .mac_col(mac_col),
    .mii_isolate(mii_isolate), .an_restart_req(an_restart_req),
    .an_restart_ack(an_restart_ack), .an_done(an_done), .an_enable(an_enable),
    .force_active(force_active), .force_speed(force_speed),
    .force_duplex(force_duplex), .far_fault_evt(far_fault_evt), .link_ok(link_ok));
  pbc_mgmt_master i_pbc_mgmt_master (.core_clk(core_clk), .mdc(mdc), .mdo(mdo),
    .mdo_en(mdo_en), .mdio_in(mdio_w));

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] d;
    i_pbc_mgmt_master.frame(OP_READ, PA, ra, 16'h0000, d);
    chk(d, exp);
  endtask
  // frame for another address is skipped: the line stays pulled up
  task automatic rd_other(input logic [4:0] pa, input logic [15:0] exp);
    logic [15:0] d;
    i_pbc_mgmt_master.frame(OP_READ, pa, REG_STAT_IDX, 16'h0000, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    logic [15:0] d;
    i_pbc_mgmt_master.frame(OP_WRITE, PA, ra, wd, d);
  endtask
  task automatic pulse(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      error_cnt++;
      wrap_up();
    end
  end

  initial begin
    pulse(4);
    rst = 1'b0;
    pulse(3);
    chk({11'h0, force_active, force_duplex, force_speed, an_enable}, 16'h000d);
    rd(REG_CTRL_IDX, 16'h1140);
    rd(REG_STAT_IDX, 16'h7948);
    rd(REG_STAT_IDX, 16'h794c);
    link_ok = 1'b0;
    far_fault_evt = 1'b1;
    an_done = 1'b1;
    pulse(1);
    link_ok = 1'b1;
    far_fault_evt = 1'b0;
    rd(REG_STAT_IDX, 16'h7978);
    rd(REG_STAT_IDX, 16'h796c);
    wr(REG_CTRL_IDX, 16'h13bf);
    chk({15'h0, an_restart_req}, 16'h0001);
    rd(REG_CTRL_IDX, 16'h1380);
    wr(REG_CTRL_IDX, 16'h1180);
    rd(REG_CTRL_IDX, 16'h1380);
    an_restart_ack = 1'b1;
    pulse(1);
    an_restart_ack = 1'b0;
    pulse(1);
    rd(REG_CTRL_IDX, 16'h1180);
    mac_tx_en = 1'b1;
    pulse(2);
    chk({15'h0, mac_col}, 16'h0001);
    mac_tx_en = 1'b0;
    pulse(2);
    chk({15'h0, mac_col}, 16'h0000);
    for (int s = 0; s < 4; s++) begin
      sp = 2'(s);
      wr(REG_CTRL_IDX, {2'b00, sp[0], 3'b000, 1'b1, sp[0], 1'b0, sp[1], 6'h00});
      chk({11'h0, an_restart_req, force_active, force_duplex, force_speed},
        {11'h0, 1'b0, 1'b1, sp[0], sp});
      rd(REG_CTRL_IDX, {2'b00, sp[0], 4'h0, sp[0], 1'b0, sp[1], 6'h00});
    end
    wr(REG_CTRL_IDX, 16'h0480);
    mac_tx_en = 1'b1;
    pulse(2);
    chk({14'h0, mii_isolate, mac_col}, 16'h0002);
    mac_tx_en = 1'b0;
    rd(REG_CTRL_IDX, 16'h0480);
    wr(REG_CTRL_IDX, 16'h0000);
    chk({15'h0, mii_isolate}, 16'h0000);
    rd(5'h02, 16'h0000);
    rd_other(5'h04, 16'hffff);
    rd(REG_STAT_IDX, 16'h796c);
    // second reset with the other strap levels; preamble needed again
    strap_an = 1'b0;
    strap_fd = 1'b0;
    rst = 1'b1;
    pulse(4);
    rst = 1'b0;
    i_pbc_mgmt_master.need_pre = 1'b1;
    pulse(3);
    chk({11'h0, force_active, force_duplex, force_speed, an_enable}, 16'h0014);
    rd(REG_CTRL_IDX, 16'h0040);
    wrap_up();
  end
endmodule // phy_basic_control_status_regs_test
`default_nettype wire
